// *** lcd_channel.sv ***
// One line channel's diagnostics: pattern generator and checker, loopbacks, all-ones sender,
// with an AXI4-Lite register slave and one level interrupt.
// Assumes all pin clocks and rails are asynchronous to sys_clk and at most a quarter of its rate.
`timescale 1ns/1ns
`include "lcd_diag_regs.svh"

module lcd_channel (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt
	output logic irq,
	// Framer side, transmit
	input wire logic tx_clock_in,
	input wire logic tx_pos_rail,
	input wire logic tx_neg_rail,
	// Framer side, receive
	output logic rx_recovered_clock,
	output logic rx_pos_rail,
	output logic rx_neg_rail_violation_out,
	// Line side
	output logic tx_line_pos,
	output logic tx_line_neg,
	input wire logic rx_line_clock,
	input wire logic rx_line_pos,
	input wire logic rx_line_neg
);

	// ====================================================================
	// State
	lcd_pkg::lcd_state_s q;
	lcd_pkg::lcd_state_s d;
	lcd_pkg::lcd_loop_e loop_mode;
	logic [`LCD_SYNC_W-1:0] pins;
	logic [`LCD_SYNC_W-1:0] rise;
	logic pat_en;
	logic all_ones;
	logic dual_rail;
	logic rate_e3;
	logic tx_edge;
	logic rx_edge;
	logic tx_bit;
	logic tx_mark;
	logic gen_fb;
	logic rx_lp;
	logic rx_ln;
	logic rx_bit;
	logic predicted;
	logic bit_err;
	logic viol;
	logic [7:0] wr_addr;
	logic [31:0] rd_word;
	logic rd_hit;
	logic rd_take;

	assign pins = {rx_line_neg, rx_line_pos, rx_line_clock, tx_neg_rail, tx_pos_rail, tx_clock_in};

	always_comb begin
		d = q;
		// ====================================================================
		// Pin synchronisers: a level counts once the second and third stages agree.
		d.s1 = pins;
		d.s2 = q.s1;
		d.s3 = q.s2;
		d.filt = (~(q.s2 ^ q.s3) & q.s3) | ((q.s2 ^ q.s3) & q.filt);
		rise = d.filt & ~q.filt;

		// ====================================================================
		// Mode decode
		pat_en = q.ctrl[`LCD_CTRL_PATTERN_EN];
		all_ones = q.ctrl[`LCD_CTRL_ALL_ONES];
		dual_rail = q.ctrl[`LCD_CTRL_DUAL_RAIL] & ~pat_en;
		rate_e3 = q.ctrl[`LCD_CTRL_RATE_E3];
		case ({q.ctrl[`LCD_CTRL_REMOTE_LOOP], q.ctrl[`LCD_CTRL_LOCAL_LOOP]})
			`LCD_LOOP_CODE_ANALOG: loop_mode = lcd_pkg::LOOP_ANALOG;
			`LCD_LOOP_CODE_DIGITAL: loop_mode = lcd_pkg::LOOP_DIGITAL;
			`LCD_LOOP_CODE_REMOTE: loop_mode = lcd_pkg::LOOP_REMOTE;
			default: loop_mode = lcd_pkg::LOOP_NORMAL;
		endcase

		// Remote loop takes its bit timing from the line clock, never the framer's.
		tx_edge = (loop_mode == lcd_pkg::LOOP_REMOTE) ? rise[`LCD_IN_RXC] : rise[`LCD_IN_TXC];
		// In analog loop the receiver sees the transmit line, timed by the transmit clock.
		rx_edge = (loop_mode == lcd_pkg::LOOP_ANALOG) ? rise[`LCD_IN_TXC] : rise[`LCD_IN_RXC];
		rx_lp = (loop_mode == lcd_pkg::LOOP_ANALOG) ? q.tx_pos : q.filt[`LCD_IN_RXP];
		rx_ln = (loop_mode == lcd_pkg::LOOP_ANALOG) ? q.tx_neg : q.filt[`LCD_IN_RXN];
		rx_bit = rx_lp | rx_ln;

		// ====================================================================
		// Error insertion request on a rising change of the insert bit only.
		d.ins_prev = q.ctrl[`LCD_CTRL_ERR_INSERT];
		if (pat_en && q.ctrl[`LCD_CTRL_ERR_INSERT] && !q.ins_prev) begin
			d.ins_pend = 1'b1;
		end
		if (!pat_en) begin
			d.ins_pend = 1'b0;
		end

		// ====================================================================
		// Transmit path
		gen_fb = rate_e3 ? (q.gen[`LCD_TAP_LONG_A] ^ q.gen[`LCD_TAP_LONG_B])
			: (q.gen[`LCD_TAP_SHORT_A] ^ q.gen[`LCD_TAP_SHORT_B]);
		tx_bit = 1'b0;
		tx_mark = 1'b0;
		if (tx_edge) begin
			if (loop_mode == lcd_pkg::LOOP_REMOTE) begin
				d.tx_pos = q.filt[`LCD_IN_RXP];
				d.tx_neg = q.filt[`LCD_IN_RXN];
			end else if (all_ones && loop_mode != lcd_pkg::LOOP_ANALOG) begin
				tx_bit = 1'b1;
				tx_mark = 1'b1;
			end else if (pat_en) begin
				d.gen = {q.gen[`LCD_LFSR_W-2:0], gen_fb};
				tx_bit = gen_fb ^ q.ins_pend;
				tx_mark = 1'b1;
				// Only a request already pending is spent; one raised in this cycle waits, or is lost if one was already pending.
				d.ins_pend = d.ins_pend & ~q.ins_pend;
			end else if (dual_rail) begin
				d.tx_pos = q.filt[`LCD_IN_TXP];
				d.tx_neg = q.filt[`LCD_IN_TXN];
			end else begin
				tx_bit = q.filt[`LCD_IN_TXP];
				tx_mark = 1'b1;
			end
			// Single-rail bits go out as alternate mark inversion.
			if (tx_mark) begin
				d.tx_pos = tx_bit & ~q.ami_pol;
				d.tx_neg = tx_bit & q.ami_pol;
				d.ami_pol = q.ami_pol ^ tx_bit;
			end
		end
		if (!pat_en) begin
			d.gen = `LCD_LFSR_SEED;
		end

		// ====================================================================
		// Receive path and checker
		predicted = rate_e3 ? (q.hist[`LCD_TAP_LONG_A] ^ q.hist[`LCD_TAP_LONG_B])
			: (q.hist[`LCD_TAP_SHORT_A] ^ q.hist[`LCD_TAP_SHORT_B]);
		bit_err = rx_bit ^ predicted;
		viol = (rx_lp && q.viol_pol) || (rx_ln && !q.viol_pol);
		d.rx_clk = (loop_mode == lcd_pkg::LOOP_NORMAL || loop_mode == lcd_pkg::LOOP_REMOTE)
			? q.filt[`LCD_IN_RXC] : q.filt[`LCD_IN_TXC];
		if (loop_mode == lcd_pkg::LOOP_DIGITAL) begin
			d.rx_pos = q.filt[`LCD_IN_TXP];
			d.rx_neg = q.filt[`LCD_IN_TXN];
		end else if (rx_edge) begin
			// While locked the checker runs on its own prediction, so one bad bit is one error.
			d.hist = {q.hist[`LCD_LFSR_W-2:0], (pat_en && q.locked) ? predicted : rx_bit};
			if (rx_lp || rx_ln) begin
				d.viol_pol = rx_lp;
			end
			if (pat_en) begin
				// The checker runs only while pattern enable is set.
				d.rx_pos = rx_bit;
				if (!q.locked) begin
					d.good_cnt = bit_err ? '0 : q.good_cnt + 1'b1;
					if (!bit_err && q.good_cnt == `LCD_LOCK_RUN - 1'b1) begin
						d.locked = 1'b1;
						d.good_cnt = '0;
						d.err_cnt = '0;
					end
				end else if (bit_err) begin
					d.err_cnt = q.err_cnt + 1'b1;
					d.good_cnt = '0;
					if (q.err_cnt == `LCD_LOSS_ERRS - 1'b1) begin
						d.locked = 1'b0;
					end
				end else if (q.good_cnt == `LCD_LOCK_RUN - 1'b1) begin
					// A long clean run forgives scattered errors.
					d.err_cnt = '0;
					d.good_cnt = '0;
				end else begin
					d.good_cnt = q.good_cnt + 1'b1;
				end
				// Held until the next receive bit, so one error is one receive clock wide.
				d.rx_neg = q.locked ? bit_err : 1'b1;
				if (!d.locked) begin
					d.rx_neg = 1'b1;
				end
			end else if (dual_rail) begin
				d.rx_pos = rx_lp;
				d.rx_neg = rx_ln;
			end else begin
				// Single rail: the negative rail carries line code violations.
				d.rx_pos = rx_bit;
				d.rx_neg = viol;
			end
		end
		if (!pat_en) begin
			d.locked = 1'b0;
			d.good_cnt = '0;
			d.err_cnt = '0;
		end

		// ====================================================================
		// AXI4-Lite write channel
		if (s_axi_awvalid && q.awready) begin
			d.aw_have = 1'b1;
			d.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && q.wready) begin
			d.w_have = 1'b1;
			d.w_data = s_axi_wdata[7:0];
			d.w_strb0 = s_axi_wstrb[0];
		end
		if (s_axi_bvalid && s_axi_bready) begin
			d.bvalid = 1'b0;
		end
		wr_addr = q.aw_addr;
		if (q.aw_have && q.w_have && !q.bvalid) begin
			d.aw_have = 1'b0;
			d.w_have = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `LCD_RESP_OKAY;
			case (wr_addr)
				`LCD_ADDR_CTRL: begin
					if (q.w_strb0) begin
						d.ctrl = q.w_data[`LCD_CTRL_W-1:0];
					end
				end
				`LCD_ADDR_INT_MASK: begin
					if (q.w_strb0) begin
						d.mask = q.w_data[`LCD_EVT_W-1:0];
					end
				end
				`LCD_ADDR_STATUS, `LCD_ADDR_INT_STATUS: begin
					d.bresp = `LCD_RESP_OKAY;
				end
				default: d.bresp = `LCD_RESP_SLVERR;
			endcase
		end

		// ====================================================================
		// AXI4-Lite read channel
		rd_word = '0;
		rd_hit = 1'b1;
		case (s_axi_araddr)
			`LCD_ADDR_CTRL: rd_word[`LCD_CTRL_W-1:0] = q.ctrl;
			`LCD_ADDR_STATUS: begin
				rd_word[`LCD_STAT_LOCK_LOST] = pat_en & ~q.locked;
				rd_word[`LCD_STAT_LOCKED] = q.locked;
			end
			`LCD_ADDR_INT_STATUS: rd_word[`LCD_EVT_W-1:0] = q.sts;
			`LCD_ADDR_INT_MASK: rd_word[`LCD_EVT_W-1:0] = q.mask;
			default: rd_hit = 1'b0;
		endcase
		rd_take = s_axi_arvalid && q.arready;
		if (s_axi_rvalid && s_axi_rready) begin
			d.rvalid = 1'b0;
		end
		if (rd_take) begin
			d.rvalid = 1'b1;
			d.rdata = rd_word;
			d.rresp = rd_hit ? `LCD_RESP_OKAY : `LCD_RESP_SLVERR;
		end

		// ====================================================================
		// Sticky events: a read clears them, but an event in the same cycle survives.
		if (rd_take && s_axi_araddr == `LCD_ADDR_INT_STATUS) begin
			d.sts = `LCD_EVT_RESET;
		end
		d.sts[`LCD_EVT_LOCK_LOST] = d.sts[`LCD_EVT_LOCK_LOST] | (q.locked & ~d.locked);
		d.sts[`LCD_EVT_LOCK_GAINED] = d.sts[`LCD_EVT_LOCK_GAINED] | (~q.locked & d.locked);
		d.sts[`LCD_EVT_BIT_ERROR] = d.sts[`LCD_EVT_BIT_ERROR] | (rx_edge & pat_en & q.locked & bit_err);
		d.irq = |(d.sts & d.mask);

		// Ready flags follow the next state so that no item is taken twice.
		d.awready = ~d.aw_have & ~d.bvalid;
		d.wready = ~d.w_have & ~d.bvalid;
		d.arready = ~d.rvalid;
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			q <= '0;
			q.ctrl <= `LCD_CTRL_RESET;
			q.mask <= `LCD_EVT_RESET;
			q.gen <= `LCD_LFSR_SEED;
		end else begin
			q <= d;
		end
	end

	// ====================================================================
	// Outputs
	assign s_axi_awready = q.awready;
	assign s_axi_wready = q.wready;
	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;
	assign irq = q.irq;
	assign tx_line_pos = q.tx_pos;
	assign tx_line_neg = q.tx_neg;
	assign rx_recovered_clock = q.rx_clk;
	assign rx_pos_rail = q.rx_pos;
	assign rx_neg_rail_violation_out = q.rx_neg;

endmodule : lcd_channel

// *** lcd_diag_regs.svh ***
// Register map, field positions, reset values and thresholds of one line channel diagnostic block.
// Assumes inclusion by bare name from the package and the channel module.
`ifndef LCD_DIAG_REGS_SVH
`define LCD_DIAG_REGS_SVH

// ====================================================================
// Register byte addresses
`define LCD_ADDR_CTRL 8'h00
`define LCD_ADDR_STATUS 8'h04
`define LCD_ADDR_INT_STATUS 8'h08
`define LCD_ADDR_INT_MASK 8'h0C

// ====================================================================
// Control fields
`define LCD_CTRL_W 7
`define LCD_CTRL_PATTERN_EN 0
`define LCD_CTRL_ERR_INSERT 1
`define LCD_CTRL_REMOTE_LOOP 2
`define LCD_CTRL_LOCAL_LOOP 3
`define LCD_CTRL_ALL_ONES 4
`define LCD_CTRL_RATE_E3 5
`define LCD_CTRL_DUAL_RAIL 6
`define LCD_CTRL_RESET 7'h00

// Status fields
`define LCD_STAT_LOCK_LOST 0
`define LCD_STAT_LOCKED 1

// Event fields shared by the sticky status and the mask
`define LCD_EVT_W 3
`define LCD_EVT_LOCK_LOST 0
`define LCD_EVT_LOCK_GAINED 1
`define LCD_EVT_BIT_ERROR 2
`define LCD_EVT_RESET 3'h0

// ====================================================================
// Loopback decode of {remote, local}
`define LCD_LOOP_CODE_NORMAL 2'b00
`define LCD_LOOP_CODE_DIGITAL 2'b01
`define LCD_LOOP_CODE_REMOTE 2'b10
`define LCD_LOOP_CODE_ANALOG 2'b11

// ====================================================================
// Pattern sequences: taps of the long and the short generator
`define LCD_LFSR_W 23
`define LCD_TAP_LONG_A 22
`define LCD_TAP_LONG_B 17
`define LCD_TAP_SHORT_A 14
`define LCD_TAP_SHORT_B 13
`define LCD_LFSR_SEED 23'h00_0001

// Checker thresholds
`define LCD_CNT_W 6
`define LCD_LOCK_RUN 6'h20
`define LCD_ERR_W 3
`define LCD_LOSS_ERRS 3'h4

// ====================================================================
// Synchronised pin inputs
`define LCD_SYNC_W 6
`define LCD_IN_TXC 0
`define LCD_IN_TXP 1
`define LCD_IN_TXN 2
`define LCD_IN_RXC 3
`define LCD_IN_RXP 4
`define LCD_IN_RXN 5

// Bus answers
`define LCD_RESP_OKAY 2'b00
`define LCD_RESP_SLVERR 2'b10

`endif

// *** lcd_pkg.sv ***
// Types of the line channel diagnostic block: loop modes and the state record.
// Assumes the register header is on the include path.
`include "lcd_diag_regs.svh"

package lcd_pkg;

	// ====================================================================
	// Loopback modes
	typedef enum logic [1:0] {LOOP_NORMAL, LOOP_ANALOG, LOOP_DIGITAL, LOOP_REMOTE} lcd_loop_e;

	// ====================================================================
	// Whole state of one channel
	typedef struct packed {
		logic [`LCD_SYNC_W-1:0] s1;
		logic [`LCD_SYNC_W-1:0] s2;
		logic [`LCD_SYNC_W-1:0] s3;
		logic [`LCD_SYNC_W-1:0] filt;
		logic aw_have;
		logic [7:0] aw_addr;
		logic w_have;
		logic [7:0] w_data;
		logic w_strb0;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [`LCD_CTRL_W-1:0] ctrl;
		logic [`LCD_EVT_W-1:0] mask;
		logic [`LCD_EVT_W-1:0] sts;
		logic ins_prev;
		logic ins_pend;
		logic [`LCD_LFSR_W-1:0] gen;
		logic ami_pol;
		logic [`LCD_LFSR_W-1:0] hist;
		logic viol_pol;
		logic locked;
		logic [`LCD_CNT_W-1:0] good_cnt;
		logic [`LCD_ERR_W-1:0] err_cnt;
		logic tx_pos;
		logic tx_neg;
		logic rx_clk;
		logic rx_pos;
		logic rx_neg;
		logic irq;
	} lcd_state_s;

endpackage : lcd_pkg

// *** lcd_channel_assertions.sv ***
// Checker of the channel block: bus answers and line marks, with only a cover of the interrupt.
// Assumes it is bound onto lcd_channel and sees only its ports.
`timescale 1ns/1ns
`include "lcd_diag_regs.svh"
module lcd_channel_assertions (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic reset_n,
	// Register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt and line
	input wire logic irq,
	input wire logic tx_line_pos,
	input wire logic tx_line_neg
);
	// ====
	// Properties
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!reset_n);
	a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped early");
	a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped early");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> ##1 s_axi_bvalid) else $error("write answer late");
	a_write_busy: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
	a_read_unmapped: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > `LCD_ADDR_INT_MASK
		|=> s_axi_rresp == 2'b10 && s_axi_rdata == 32'h0000_0000) else $error("unmapped read");
	a_marks_apart: assert property (!(tx_line_pos && tx_line_neg))
		else $error("both line marks high");
	a_mark_held: assert property ($rose(tx_line_pos) |=> tx_line_pos [*4])
		else $error("line mark too short");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_unmapped: cover property (s_axi_rvalid && s_axi_rready && s_axi_rresp == 2'b10);
	c_irq: cover property ($rose(irq));
endmodule : lcd_channel_assertions

bind lcd_channel lcd_channel_assertions i_chk (.*);

// *** lcd_framer_model.sv ***
// Framer model: makes the transmit clock within frames and drives the transmit rails.
// Assumes the bench chooses the rail levels and when the clock runs.
`timescale 1ns/1ns
module lcd_framer_model (
	// Control from the bench
	input wire logic run,
	input wire logic pos_bit,
	input wire logic neg_bit,
	// Transmit pins
	output logic tx_clock_in,
	output logic tx_pos_rail,
	output logic tx_neg_rail
);
	// ====
	// Clock
	// It stops low between frames, so no half pulse reaches the block.
	initial begin
		tx_clock_in = 1'b0;
		forever begin
			#160;
			if (run || tx_clock_in) tx_clock_in = ~tx_clock_in;
		end
	end
	// ====
	// Rails
	// They change on the falling edge so they are settled at every rise.
	initial begin
		tx_pos_rail = 1'b0;
		tx_neg_rail = 1'b0;
	end
	always @(negedge tx_clock_in) begin
		tx_pos_rail <= pos_bit;
		tx_neg_rail <= neg_bit;
	end
endmodule : lcd_framer_model

// *** liu_channel_diagnostics_bench.sv ***
// Self-checking bench of one channel: register rows, loop and all-ones codes, pattern lock.
// Assumes the framer model drives the transmit pins and wires loop the line back.
`timescale 1ns/1ns
`include "lcd_diag_regs.svh"
module liu_channel_diagnostics_bench;
	typedef struct {logic wr; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic [1:0] r;} lcd_row_s;
	logic sys_clk, reset_n, irq, run, pos_bit, neg_bit, sp, sn;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
	logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic tx_clock_in, tx_pos_rail, tx_neg_rail, rx_recovered_clock, rx_pos_rail;
	logic rx_neg_rail_violation_out, tx_line_pos, tx_line_neg;
	logic rx_line_clock, rx_line_pos, rx_line_neg;
	logic [3:0] s_axi_wstrb = 4'hF;
	int n_mismatch = 0;
	int cmp_count = 0;
	int i, n, m;
	lcd_row_s rows [12] = '{'{0, 8'h00, 0, 0, 0}, '{0, 8'h04, 0, 0, 0}, '{0, 8'h08, 0, 0, 0},
		'{0, 8'h0C, 0, 0, 0}, '{0, 8'h10, 0, 0, 2}, '{1, 8'h10, 1, 0, 2}, '{1, 8'h04, 255, 0, 0},
		'{0, 8'h04, 0, 0, 0}, '{1, 8'h0C, 255, 0, 0}, '{0, 8'h0C, 0, 7, 0}, '{1, 8'h0C, 4, 0, 0},
		'{0, 8'h00, 0, 0, 0}};
	logic [7:0] codes [4] = '{8'h14, 8'h10, 8'h18, 8'h1C};
	logic [7:0] pats [2] = '{8'h41, 8'h21};
	// ====
	// Design, framer and line loop
	// The line is wired back so the checker sees the generator's own pattern.
	assign rx_line_clock = tx_clock_in;
	assign rx_line_pos = tx_line_pos;
	assign rx_line_neg = tx_line_neg;
	lcd_channel i_dut (.*);
	lcd_framer_model i_framer (.*);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	// ====
	// Tasks
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : chk
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask : give_verdict
	task automatic over(input int k, input int lim);
		if (k >= lim) begin
			n_mismatch++;
			$display("BAD %0t wait ran out", $time);
			give_verdict();
		end
	endtask : over
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge sys_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		over(k, 50);
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int k;
		@(posedge sys_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (k = 0; k < 50; k++) begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		over(k, 50);
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask : axi_rd
	// ====
	// Main sequence
	initial begin
		{reset_n, run, pos_bit, neg_bit, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 7'h00;
		{s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 50'h0;
		repeat (10) @(posedge sys_clk);
		reset_n <= 1'b1;
		run <= 1'b1;
		for (i = 0; i < 12; i++) begin
			if (rows[i].wr) axi_wr(rows[i].a, rows[i].d, rs);
			else axi_rd(rows[i].a, rd, rs);
			if (!rows[i].wr) chk(rd, rows[i].x);
			chk(32'(rs), 32'(rows[i].r));
		end
		// Remote loop first, while the looped line is still quiet.
		for (i = 0; i < 4; i++) begin
			axi_wr(`LCD_ADDR_CTRL, {24'h00_0000, codes[i]}, rs);
			pos_bit <= 1'b1;
			repeat (24) @(posedge sys_clk);
			{sp, sn} = 2'b00;
			repeat (64) begin
				@(posedge sys_clk);
				sp |= tx_line_pos;
				sn |= tx_line_neg;
			end
			chk(32'({sp, sn}), (i == 0) ? 32'h0 : 32'h3);
		end
		axi_wr(`LCD_ADDR_CTRL, 32'h0000_0048, rs);
		repeat (24) @(posedge sys_clk);
		chk(32'({rx_pos_rail, rx_neg_rail_violation_out}), 32'h2);
		{sp, sn} = 2'b01;
		repeat (16) begin
			@(posedge sys_clk);
			sp |= rx_recovered_clock;
			sn &= rx_recovered_clock;
		end
		chk(32'({sp, sn}), 32'h2);
		for (i = 0; i < 2; i++) begin
			axi_wr(`LCD_ADDR_CTRL, 32'h0000_0000, rs);
			axi_wr(`LCD_ADDR_CTRL, {24'h00_0000, pats[i]}, rs);
			axi_rd(`LCD_ADDR_STATUS, rd, rs);
			chk(rd, 32'h1);
			repeat (12) @(posedge sys_clk);
			chk(32'(rx_neg_rail_violation_out), 32'h1);
			for (n = 0; n < 3000 && rx_neg_rail_violation_out !== 1'b0; n++) @(posedge sys_clk);
			over(n, 3000);
			axi_rd(`LCD_ADDR_STATUS, rd, rs);
			chk(rd, 32'h2);
		end
		axi_rd(`LCD_ADDR_INT_STATUS, rd, rs);
		axi_wr(`LCD_ADDR_CTRL, 32'h0000_0023, rs);
		for (n = 0; n < 800 && rx_neg_rail_violation_out !== 1'b1; n++) @(posedge sys_clk);
		over(n, 800);
		for (m = 0; m < 40 && rx_neg_rail_violation_out === 1'b1; m++) @(posedge sys_clk);
		chk(32'(m > 5 && m < 11), 32'h1);
		chk(32'(irq), 32'h1);
		axi_rd(`LCD_ADDR_INT_STATUS, rd, rs);
		chk(rd, 32'h4);
		repeat (3) @(posedge sys_clk);
		chk(32'(irq), 32'h0);
		// The insert bit stays set, so no second error may follow.
		sp = 1'b0;
		repeat (800) begin
			@(posedge sys_clk);
			sp |= rx_neg_rail_violation_out;
		end
		chk(32'(sp), 32'h0);
		reset_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		axi_rd(`LCD_ADDR_CTRL, rd, rs);
		chk(rd, 32'h0);
		chk(32'(irq), 32'h0);
		give_verdict();
	end
endmodule : liu_channel_diagnostics_bench
